// >>> verilog/pivc_top.sv
`timescale 1ns/100ps
module pivc_top #(
  parameter int NI = pivc_pkg::NUM_IRQ,
  parameter int NT = pivc_pkg::NUM_TRAP
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [NI-1:0] irq_in,
  input wire logic [NT-1:0] trap_in,
  input wire logic cpu_ack,
  input wire logic cpu_ret,
  input wire logic [3:0] cpu_ret_level,
  output logic cpu_irq,
  output logic [7:0] cpu_vec_num,
  output logic [23:0] cpu_vec_addr,
  output logic [23:0] cpu_handler,
  output logic [3:0] cpu_level,
  output logic cpu_busy,
  output logic int_out
);
  localparam int NV = NT + NI;

  pivc_pkg::pivc_state_t st_q;
  logic [NI-1:0] irq_pend_q;
  logic [NI-1:0] irq_en_q;
  logic [3*NI-1:0] irq_lvl_q;
  logic [NT-1:0] trap_pend_q;
  logic [3:0] level_q;
  logic [7:0] sel_q;
  logic [2:0] ev_q;
  logic [2:0] mask_q;
  logic [3:0] cnt_q;
  logic win_valid_q;
  logic [7:0] win_idx_q;
  logic [3:0] win_lvl_q;
  logic irq_q;
  logic [7:0] vnum_q;
  logic [23:0] vaddr_q;
  logic [23:0] handler_q;
  logic [3:0] req_lvl_q;
  logic busy_q;
  logic int_q;
  logic hready_q;
  logic [31:0] hrdata_q;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [7:0] ofs_q;
  logic [NV-1:0] pend_all;
  logic [4*NV-1:0] lvl_all;
  logic win_valid;
  logic [7:0] win_idx;
  logic [3:0] win_lvl;
  logic [23:0] tab_rd;
  logic [23:0] tab_hd;
  logic take;
  logic ack_now;
  logic ret_now;
  logic [2:0] ev_set;
  logic wr_cfg;
  logic [31:0] rd_mux;

  // Traps take fixed levels above any user level; disabled sources sit at zero
  always_comb begin
    pend_all = {irq_pend_q, trap_pend_q}; // R1
    lvl_all = '0;
    for (int i = 0; i < NT; i++) begin
      lvl_all[4*i +: 4] = pivc_pkg::TRAP_TOP_LVL - 4'(i); // R5 R7
    end
    for (int j = 0; j < NI; j++) begin
      lvl_all[4*(NT+j) +: 4] = irq_en_q[j] ? {1'b0, irq_lvl_q[3*j +: 3]} : 4'h0; // R2
    end
  end

  pivc_arbiter #(.NV(NV)) u_arb (
    .pend(pend_all),
    .lvl(lvl_all),
    .cpu_lvl(level_q),
    .win_valid(win_valid),
    .win_idx(win_idx),
    .win_lvl(win_lvl)
  );

  pivc_vec_table #(.NV(NV), .W(pivc_pkg::VEC_W)) u_tab (
    .mclk(mclk),
    .reset(reset),
    .wr_en(wr_pend_q && (ofs_q == pivc_pkg::OFS_VEC_DATA)),
    .wr_idx(sel_q),
    .wr_data(hwdata[23:0]),
    .rd_a_idx(sel_q),
    .rd_a_data(tab_rd),
    .rd_b_idx(win_idx_q),
    .rd_b_data(tab_hd)
  );

  // AHB-Lite: writes zero wait, reads one wait state
  assign take = hsel && hready && htrans[1];
  assign wr_cfg = wr_pend_q && (ofs_q == pivc_pkg::OFS_SRC_CFG);
  always_ff @(posedge mclk) begin
    if (reset) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      ofs_q <= 8'h00;
      hready_q <= 1'b1;
      hrdata_q <= 32'h00000000;
    end else begin
      wr_pend_q <= take && hwrite;
      rd_pend_q <= take && !hwrite;
      if (take) begin
        ofs_q <= (haddr[31:8] == 24'h000000) ? {haddr[7:2], 2'b00} : 8'hFF;
      end
      if (take && !hwrite) begin
        hready_q <= 1'b0;
      end else if (rd_pend_q) begin
        hready_q <= 1'b1;
        hrdata_q <= rd_mux;
      end
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    case (ofs_q)
      pivc_pkg::OFS_CORE_CTRL: rd_mux[pivc_pkg::CC_MSB_BIT] = level_q > pivc_pkg::USER_MAX_LVL; // R10 R11
      pivc_pkg::OFS_STATUS_WORD: rd_mux[pivc_pkg::SW_LVL_LSB +: 3] = level_q[2:0]; // R10
      pivc_pkg::OFS_SRC_SEL: rd_mux[7:0] = sel_q;
      pivc_pkg::OFS_SRC_CFG: begin
        if (int'(sel_q) < NI) begin
          rd_mux[pivc_pkg::CFG_EN_BIT] = irq_en_q[sel_q];
          rd_mux[pivc_pkg::CFG_LVL_LSB +: 3] = irq_lvl_q[3*sel_q +: 3];
          rd_mux[pivc_pkg::CFG_PEND_BIT] = irq_pend_q[sel_q];
        end
      end
      pivc_pkg::OFS_VEC_DATA: rd_mux[23:0] = tab_rd; // R8
      pivc_pkg::OFS_ACTIVE: begin
        rd_mux[7:0] = vnum_q;
        rd_mux[pivc_pkg::ACT_REQ_BIT] = irq_q;
        rd_mux[pivc_pkg::ACT_BUSY_BIT] = busy_q;
        rd_mux[pivc_pkg::ACT_LVL_LSB +: 4] = level_q;
      end
      pivc_pkg::OFS_INT_STAT: rd_mux[2:0] = ev_q;
      pivc_pkg::OFS_INT_MASK: rd_mux[2:0] = mask_q;
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Source configuration and selector
  always_ff @(posedge mclk) begin
    if (reset) begin
      sel_q <= pivc_pkg::SEL_RST;
      irq_en_q <= '0;
      irq_lvl_q <= '0; // R12
      mask_q <= pivc_pkg::MASK_RST;
    end else if (wr_pend_q) begin
      if (ofs_q == pivc_pkg::OFS_SRC_SEL) begin
        sel_q <= hwdata[7:0];
      end
      if (wr_cfg && (int'(sel_q) < NI)) begin
        irq_en_q[sel_q] <= hwdata[pivc_pkg::CFG_EN_BIT];
        irq_lvl_q[3*sel_q +: 3] <= hwdata[pivc_pkg::CFG_LVL_LSB +: 3]; // R2
      end
      if (ofs_q == pivc_pkg::OFS_INT_MASK) begin
        mask_q <= hwdata[2:0];
      end
    end
  end

  // Pending flags: a new request wins over any clear
  assign ack_now = (st_q == pivc_pkg::PIVC_REQ) && cpu_ack;
  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_pend_q <= '0;
      trap_pend_q <= '0;
    end else begin
      for (int j = 0; j < NI; j++) begin
        if (irq_in[j]) begin
          irq_pend_q[j] <= 1'b1;
        end else if ((ack_now && (int'(vnum_q) == NT + j)) ||
                     (wr_cfg && (int'(sel_q) == j) && hwdata[pivc_pkg::CFG_PEND_BIT])) begin
          irq_pend_q[j] <= 1'b0;
        end
      end
      for (int i = 0; i < NT; i++) begin
        if (trap_in[i]) begin
          trap_pend_q[i] <= 1'b1; // R5
        end else if (ack_now && (int'(vnum_q) == i)) begin
          trap_pend_q[i] <= 1'b0;
        end
      end
    end
  end

  // Registered arbitration result
  always_ff @(posedge mclk) begin
    if (reset) begin
      win_valid_q <= 1'b0;
      win_idx_q <= 8'h00;
      win_lvl_q <= 4'h0;
    end else begin
      win_valid_q <= win_valid;
      win_idx_q <= win_idx;
      win_lvl_q <= win_lvl;
    end
  end

  // Request, entry and return sequencing
  assign ret_now = (st_q == pivc_pkg::PIVC_IDLE) && cpu_ret;
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_q <= pivc_pkg::PIVC_IDLE;
      cnt_q <= 4'h0;
      irq_q <= 1'b0;
      busy_q <= 1'b0;
      vnum_q <= 8'h00;
      vaddr_q <= 24'h000000;
      handler_q <= 24'h000000;
      req_lvl_q <= 4'h0;
      level_q <= pivc_pkg::LEVEL_RST; // R12
    end else begin
      case (st_q)
        pivc_pkg::PIVC_IDLE, pivc_pkg::PIVC_REQ: begin
          if (ack_now) begin
            st_q <= pivc_pkg::PIVC_ENTRY;
            cnt_q <= pivc_pkg::ENTRY_CNT; // R4
            irq_q <= 1'b0;
            busy_q <= 1'b1;
            level_q <= req_lvl_q; // R2
          end else if (ret_now) begin
            st_q <= pivc_pkg::PIVC_RET;
            cnt_q <= pivc_pkg::RETURN_CNT; // R4
            busy_q <= 1'b1;
          end else if (win_valid_q && (win_lvl_q > level_q)) begin
            st_q <= pivc_pkg::PIVC_REQ;
            irq_q <= 1'b1; // R1 R13
            vnum_q <= win_idx_q;
            vaddr_q <= pivc_pkg::vec_addr(win_idx_q); // R6
            handler_q <= tab_hd; // R8
            req_lvl_q <= win_lvl_q;
          end else begin
            st_q <= pivc_pkg::PIVC_IDLE;
            irq_q <= 1'b0;
          end
          if (!ack_now && !ret_now && wr_pend_q) begin
            if (ofs_q == pivc_pkg::OFS_STATUS_WORD) begin
              level_q <= {1'b0, hwdata[pivc_pkg::SW_LVL_LSB +: 3]}; // R10
            end
          end
        end
        pivc_pkg::PIVC_ENTRY, pivc_pkg::PIVC_RET: begin
          if (cnt_q == 4'h0) begin
            st_q <= pivc_pkg::PIVC_IDLE;
            busy_q <= 1'b0;
            if (st_q == pivc_pkg::PIVC_RET) begin
              level_q <= cpu_ret_level;
            end
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        default: begin
          st_q <= pivc_pkg::PIVC_IDLE;
          irq_q <= 1'b0;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  // Sticky events, write one to clear, set wins
  assign ev_set[pivc_pkg::EV_REQ_BIT] = !irq_q && (st_q != pivc_pkg::PIVC_ENTRY) &&
    (st_q != pivc_pkg::PIVC_RET) && win_valid_q && (win_lvl_q > level_q) && !cpu_ret;
  assign ev_set[pivc_pkg::EV_ENTRY_BIT] = (st_q == pivc_pkg::PIVC_ENTRY) && (cnt_q == 4'h0);
  assign ev_set[pivc_pkg::EV_RET_BIT] = (st_q == pivc_pkg::PIVC_RET) && (cnt_q == 4'h0);
  always_ff @(posedge mclk) begin
    if (reset) begin
      ev_q <= 3'h0;
      int_q <= 1'b0;
    end else begin
      if (wr_pend_q && (ofs_q == pivc_pkg::OFS_INT_STAT)) begin
        ev_q <= (ev_q & ~hwdata[2:0]) | ev_set;
      end else begin
        ev_q <= ev_q | ev_set;
      end
      int_q <= |(ev_q & mask_q);
    end
  end

  assign hreadyout = hready_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign cpu_irq = irq_q;
  assign cpu_vec_num = vnum_q;
  assign cpu_vec_addr = vaddr_q;
  assign cpu_handler = handler_q;
  assign cpu_level = level_q;
  assign cpu_busy = busy_q;
  assign int_out = int_q;

  req_above_a: assert property (@(posedge mclk) disable iff (reset) // R13
    cpu_irq && !$past(wr_pend_q) |-> req_lvl_q > level_q)
    else $error("request level not above core level");
  entry_len_a: assert property (@(posedge mclk) disable iff (reset) // R4
    ack_now |=> cpu_busy [*3] ##1 !cpu_busy)
    else $error("entry latency wrong");
  ret_len_a: assert property (@(posedge mclk) disable iff (reset) // R4
    ret_now && !ack_now |=> cpu_busy [*2] ##1 (!cpu_busy && cpu_level == $past(cpu_ret_level)))
    else $error("return latency wrong");
  vec_addr_a: assert property (@(posedge mclk) disable iff (reset) // R6
    cpu_irq |-> cpu_vec_addr == 24'h000004 + {15'h0000, cpu_vec_num, 1'b0})
    else $error("vector address off table");
  prio_msb_a: assert property (@(posedge mclk) disable iff (reset) // R11
    rd_pend_q && ofs_q == pivc_pkg::OFS_CORE_CTRL |=> hrdata[3] == ($past(cpu_level) > 4'h7))
    else $error("level msb wrong");
  trap_first_a: assert property (@(posedge mclk) disable iff (reset) // R9
    trap_pend_q[0] && level_q < 4'hF |=> win_valid_q && win_idx_q == 8'h00)
    else $error("vector zero not first");
  ack_level_a: assert property (@(posedge mclk) disable iff (reset) // R2
    ack_now |=> cpu_level == $past(req_lvl_q) && !cpu_irq)
    else $error("level not taken on entry");
  trap_sticky_a: assert property (@(posedge mclk) disable iff (reset) // R5
    trap_in[0] |=> trap_pend_q[0])
    else $error("trap not latched");
  reset_clear_a: assert property (@(posedge mclk) // R12
    reset |=> !cpu_irq && cpu_level == 4'h0 && !cpu_busy)
    else $error("reset did not clear");
  one_req_a: assert property (@(posedge mclk) disable iff (reset) // R1
    $rose(cpu_irq) |-> $past(pend_all[win_idx_q], 2) || $past(win_valid_q))
    else $error("request without pending source");
endmodule

// >>> verilog/pivc_pkg.sv
// Notes on behaviour
// R1: All peripheral requests merge into one request line towards the core.
// R2: Software gives each source one of eight levels, used in arbitration.
// R3: Equal-level pending sources are resolved by a fixed order.
// R4: Entry and return each take a constant number of cycles.
// R5: Up to eight exception and trap sources besides peripheral sources.
// R6: Vector table sits in program memory from word address 000004h.
// R7: Eight unmaskable trap vectors plus up to 151 maskable interrupt vectors.
// R8: Each entry is a 24-bit service routine start address handed to the core.
// R9: Lower table position outranks higher; vector zero outranks all. Code ranks by level first, table position only between equal levels.
// R10: Core level is 4 bits: msb in core control, low three in status bits 7:5.
// R11: Level msb reads one above level 7, zero at 7 or below.
// R12: Reset clears registers and zeroes the level, no exception taken.
// R13: Request raised only when winner level exceeds core level; its vector shown.
package pivc_pkg;
  localparam int NUM_IRQ = 151;
  localparam int NUM_TRAP = 8;
  localparam int NUM_VEC = 159;
  localparam int VEC_W = 24;
  localparam int LVL_W = 4;
  localparam int ULVL_W = 3;
  localparam logic [23:0] TABLE_BASE = 24'h000004;
  localparam logic [3:0] TRAP_TOP_LVL = 4'hF;
  localparam logic [3:0] USER_MAX_LVL = 4'h7;
  // Fixed latencies in cycles
  localparam int ENTRY_CYCLES = 3;
  localparam int RETURN_CYCLES = 2;
  localparam logic [3:0] ENTRY_CNT = 4'(ENTRY_CYCLES - 1);
  localparam logic [3:0] RETURN_CNT = 4'(RETURN_CYCLES - 1);
  // Register byte offsets
  localparam logic [7:0] OFS_CORE_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS_WORD = 8'h04;
  localparam logic [7:0] OFS_SRC_SEL = 8'h08;
  localparam logic [7:0] OFS_SRC_CFG = 8'h0C;
  localparam logic [7:0] OFS_VEC_DATA = 8'h10;
  localparam logic [7:0] OFS_ACTIVE = 8'h14;
  localparam logic [7:0] OFS_INT_STAT = 8'h18;
  localparam logic [7:0] OFS_INT_MASK = 8'h1C;
  // Field positions
  localparam int CC_MSB_BIT = 3;
  localparam int SW_LVL_LSB = 5;
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_LVL_LSB = 4;
  localparam int CFG_PEND_BIT = 8;
  localparam int ACT_REQ_BIT = 8;
  localparam int ACT_BUSY_BIT = 9;
  localparam int ACT_LVL_LSB = 12;
  localparam int EV_REQ_BIT = 0;
  localparam int EV_ENTRY_BIT = 1;
  localparam int EV_RET_BIT = 2;
  localparam int EV_W = 3;
  // Reset values
  localparam logic [3:0] LEVEL_RST = 4'h0;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam logic [7:0] SEL_RST = 8'h00;

  typedef enum logic [3:0] {
    PIVC_IDLE  = 4'b0001,
    PIVC_REQ   = 4'b0010,
    PIVC_ENTRY = 4'b0100,
    PIVC_RET   = 4'b1000
  } pivc_state_t;

  // Program-memory word address of a vector
  function automatic logic [23:0] vec_addr(input logic [7:0] num);
    vec_addr = TABLE_BASE + {15'h0000, num, 1'b0};
  endfunction
endpackage

// >>> verilog/pivc_vec_table.sv
`timescale 1ns/100ps
module pivc_vec_table #(
  parameter int NV = pivc_pkg::NUM_VEC,
  parameter int W = pivc_pkg::VEC_W
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [7:0] wr_idx,
  input wire logic [W-1:0] wr_data,
  input wire logic [7:0] rd_a_idx,
  output logic [W-1:0] rd_a_data,
  input wire logic [7:0] rd_b_idx,
  output logic [W-1:0] rd_b_data
);
  logic [W-1:0] mem [NV];

  // Entries cleared on reset
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < NV; i++) begin
        mem[i] <= '0;
      end
    end else if (wr_en && (int'(wr_idx) < NV)) begin
      mem[wr_idx] <= wr_data;
    end
  end

  assign rd_a_data = (int'(rd_a_idx) < NV) ? mem[rd_a_idx] : '0;
  assign rd_b_data = (int'(rd_b_idx) < NV) ? mem[rd_b_idx] : '0;
endmodule

// >>> verilog/pivc_arbiter.sv
`timescale 1ns/100ps
module pivc_arbiter #(
  parameter int NV = pivc_pkg::NUM_VEC
) (
  input wire logic [NV-1:0] pend,
  input wire logic [4*NV-1:0] lvl,
  input wire logic [3:0] cpu_lvl,
  output logic win_valid,
  output logic [7:0] win_idx,
  output logic [3:0] win_lvl
);
  // Ascending scan with strict compare keeps the lowest index on ties
  always_comb begin
    win_idx = 8'h00;
    win_lvl = 4'h0;
    win_valid = 1'b0;
    for (int i = 0; i < NV; i++) begin
      if (pend[i] && (lvl[4*i +: 4] > win_lvl)) begin // R3 R9
        win_lvl = lvl[4*i +: 4];
        win_idx = 8'(i);
      end
    end
    win_valid = win_lvl > cpu_lvl; // R13
  end
endmodule

// >>> bench/pivc_core_model.sv
`timescale 1ns/100ps
module pivc_core_model (
  input wire logic mclk,
  input wire logic reset,
  input wire logic cpu_irq,
  input wire logic cpu_busy,
  input wire logic ret_go,
  input wire logic [3:0] ack_wait,
  input wire logic [7:0] cpu_vec_num,
  input wire logic [23:0] cpu_vec_addr,
  input wire logic [23:0] cpu_handler,
  output logic cpu_ack,
  output logic cpu_ret,
  output logic [3:0] cpu_ret_level,
  output int acks,
  output logic [7:0] got_num,
  output logic [23:0] got_addr,
  output logic [23:0] got_handler
);
  logic [3:0] wait_q;
  logic want_q;
  assign cpu_ret_level = 4'h0;
  // Acks after a programmable wait, latches what it took
  always_ff @(posedge mclk) begin
    if (reset) begin
      wait_q <= 4'h0;
      cpu_ack <= 1'b0;
      acks <= 0;
      got_num <= 8'h00;
      got_addr <= 24'h000000;
      got_handler <= 24'h000000;
    end else begin
      wait_q <= (cpu_irq && !cpu_ack) ? wait_q + 4'h1 : 4'h0;
      cpu_ack <= cpu_irq && !cpu_ack && (wait_q >= ack_wait);
      if (cpu_ack && cpu_irq) begin
        acks <= acks + 1;
        got_num <= cpu_vec_num;
        got_addr <= cpu_vec_addr;
        got_handler <= cpu_handler;
      end
    end
  end
  // Return pulse once idle and not requesting
  always_ff @(posedge mclk) begin
    if (reset) begin
      want_q <= 1'b0;
      cpu_ret <= 1'b0;
    end else begin
      if (ret_go) begin
        want_q <= 1'b1;
      end else if (cpu_ret) begin
        want_q <= 1'b0;
      end
      cpu_ret <= want_q && !cpu_ret && !cpu_busy && !cpu_irq && !cpu_ack;
    end
  end
endmodule

// >>> bench/pivc_top_tb.sv
`timescale 1ns/100ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin num_errors++; \
  $display("unexpected %s expected %h seen %h", n, e, s); end end
module pivc_top_tb;
  logic mclk, reset, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [150:0] irq_in;
  logic [7:0] trap_in, cpu_vec_num, got_num, blen, bcnt;
  logic cpu_ack, cpu_ret, cpu_irq, cpu_busy, int_out, ret_go;
  logic [3:0] cpu_ret_level, cpu_level, ack_wait;
  logic [23:0] cpu_vec_addr, cpu_handler, got_addr, got_handler;
  logic [7:0] nums [5];
  int acks, seen, num_errors, comparisons;
  assign hready = hreadyout;
  pivc_top u_pivc_top (.mclk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .irq_in, .trap_in, .cpu_ack, .cpu_ret,
    .cpu_ret_level, .cpu_irq, .cpu_vec_num, .cpu_vec_addr, .cpu_handler, .cpu_level,
    .cpu_busy, .int_out);
  pivc_core_model u_pivc_core_model (.mclk, .reset, .cpu_irq, .cpu_busy, .ret_go,
    .ack_wait, .cpu_vec_num, .cpu_vec_addr, .cpu_handler, .cpu_ack, .cpu_ret,
    .cpu_ret_level, .acks, .got_num, .got_addr, .got_handler);
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Length of each busy stretch
  always @(posedge mclk) begin
    if (cpu_busy) begin
      bcnt <= bcnt + 8'h01;
    end else if (bcnt != 8'h00) begin
      blen <= bcnt;
      bcnt <= 8'h00;
    end
  end
  task test_done;
    if (num_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do begin @(posedge mclk); end while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h00000000;
    do begin @(posedge mclk); end while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, {24'h000000, a}, d);
  endtask
  task automatic rd(input logic [7:0] a);
    ahb(1'b0, {24'h000000, a}, 32'h00000000);
  endtask
  task automatic cfg(input logic [7:0] n, input logic [2:0] l);
    wr(pivc_pkg::OFS_SRC_SEL, {24'h000000, n});
    wr(pivc_pkg::OFS_SRC_CFG, {25'h0000000, l, 4'h1});
  endtask
  task automatic fire(input logic [150:0] iv, input logic [7:0] tv);
    irq_in <= iv;
    trap_in <= tv;
    @(posedge mclk);
    irq_in <= '0;
    trap_in <= 8'h00;
  endtask
  task automatic wt(input logic v);
    int n;
    n = 0;
    while (cpu_busy !== v && n < 40) begin @(posedge mclk); n++; end
    if (n >= 40) num_errors++;
  endtask
  task automatic serve(input logic [7:0] num, input logic [3:0] l);
    int n;
    n = 0;
    while (acks == seen && n < 100) begin @(posedge mclk); n++; end
    if (n >= 100) num_errors++;
    seen = acks;
    `CHK("vec_num", num, got_num)
    `CHK("vec_addr", pivc_pkg::TABLE_BASE + {15'h0000, num, 1'b0}, got_addr)
    `CHK("handler", {16'hA500, num}, got_handler)
    rd(pivc_pkg::OFS_CORE_CTRL);
    `CHK("core_control", {28'h0000000, l > 4'h7, 3'h0}, q)
    rd(pivc_pkg::OFS_STATUS_WORD);
    `CHK("status_word", {24'h000000, l[2:0], 5'h00}, q)
    `CHK("cpu_level", l, cpu_level)
    wt(1'b0);
    @(posedge mclk);
    `CHK("entry_len", 8'h03, blen)
    ret_go <= 1'b1;
    @(posedge mclk);
    ret_go <= 1'b0;
    wt(1'b1);
    wt(1'b0);
    @(posedge mclk);
    `CHK("return_len", 8'h02, blen)
    `CHK("ret_level", 4'h0, cpu_level)
  endtask
  initial begin
    #400000;
    num_errors++;
    test_done;
  end
  initial begin
    reset = 1'b1;
    {hsel, hwrite, ret_go} = 3'h0;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    htrans = 2'h0;
    hsize = 3'h2;
    irq_in = '0;
    trap_in = 8'h00;
    ack_wait = 4'h0;
    bcnt = 8'h00;
    blen = 8'h00;
    {seen, num_errors, comparisons} = '0;
    nums = '{8'h00, 8'h03, 8'h0A, 8'h0D, 8'h0F};
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    `CHK("irq_reset", 1'b0, cpu_irq)
    `CHK("level_reset", 4'h0, cpu_level)
    rd(pivc_pkg::OFS_CORE_CTRL);
    `CHK("cc_reset", 32'h00000000, q)
    foreach (nums[i]) begin
      wr(pivc_pkg::OFS_SRC_SEL, {24'h000000, nums[i]});
      wr(pivc_pkg::OFS_VEC_DATA, {16'h00A5, 8'h00, nums[i]});
    end
    rd(pivc_pkg::OFS_VEC_DATA);
    `CHK("table_rd", 32'h00A5000F, q)
    cfg(8'h05, 3'h3);
    fire(151'h1 << 5, 8'h00);
    serve(8'h0D, 4'h3);
    rd(pivc_pkg::OFS_INT_STAT);
    `CHK("int_stat", 32'h00000007, q)
    `CHK("int_masked", 1'b0, int_out)
    wr(pivc_pkg::OFS_INT_MASK, 32'h00000001);
    repeat (2) @(posedge mclk);
    `CHK("int_on", 1'b1, int_out)
    wr(pivc_pkg::OFS_INT_STAT, 32'h00000007);
    rd(pivc_pkg::OFS_INT_STAT);
    `CHK("int_clr", 32'h00000000, q)
    `CHK("int_off", 1'b0, int_out)
    cfg(8'h02, 3'h3);
    cfg(8'h07, 3'h5);
    fire((151'h1 << 2) | (151'h1 << 7), 8'h00);
    serve(8'h0F, 4'h5);
    serve(8'h0A, 4'h3);
    cfg(8'h02, 3'h4);
    cfg(8'h07, 3'h4);
    fire((151'h1 << 7) | (151'h1 << 2), 8'h00);
    serve(8'h0A, 4'h4);
    serve(8'h0F, 4'h4);
    wr(pivc_pkg::OFS_STATUS_WORD, 32'h000000A0);
    cfg(8'h05, 3'h5);
    fire(151'h1 << 5, 8'h00);
    repeat (8) @(posedge mclk);
    `CHK("no_request", 1'b0, cpu_irq)
    rd(pivc_pkg::OFS_SRC_CFG);
    `CHK("src_cfg", 32'h00000151, q)
    rd(pivc_pkg::OFS_ACTIVE);
    `CHK("active", 32'h0000500F, q)
    wr(pivc_pkg::OFS_STATUS_WORD, 32'h00000080);
    serve(8'h0D, 4'h5);
    wr(pivc_pkg::OFS_STATUS_WORD, 32'h000000E0);
    rd(pivc_pkg::OFS_CORE_CTRL);
    `CHK("cc_lvl7", 32'h00000000, q)
    wr(pivc_pkg::OFS_STATUS_WORD, 32'h00000000);
    ack_wait <= 4'h5;
    fire('0, 8'h09);
    serve(8'h00, 4'hF);
    serve(8'h03, 4'hC);
    ahb(1'b0, 32'h00000100, 32'h00000000);
    `CHK("unmapped", 32'h00000000, q)
    `CHK("hresp", 1'b0, hresp)
    test_done;
  end
endmodule
